// [shared/epv_pkg.sv]
// Pin map, operation codes and timing counts for the byte-memory programmer
package epv_pkg;
    // Device geometry and number of paralleled sockets
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int DEV_COUNT = 2;
    localparam int DEV_W = 1;
    localparam int WAIT_W = 17;
    localparam int TRY_W = 5;

    // Host operations
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_SIG = 2'h2;

    // Clock and pin timing, each time in ns as printed
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SETUP_NS = 2000;
    localparam int T_HOLD_NS = 2000;
    localparam int T_PULSE_NS = 1000000;
    localparam int T_FLOAT_NS = 130;
    localparam int T_ACC_NS = 300;
    localparam int SYNC_STAGES = 2;

    // Least times round up to whole cycles
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Pulses allowed per byte before the byte is declared failed
    localparam int MAX_TRIES = 25;

    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_TURN, S_VERIFY, S_CHECK, S_RELEASE, S_FINISH
    } epv_state_t;
endpackage

// [src/epv_sync.sv]
// Two-stage synchroniser for pins sampled from the device
`timescale 1ns/1ps
module epv_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// [src/epv_programmer.sv]
// Programmer that drives the memory pins for read, program-verify and signature
`timescale 1ns/1ps
module epv_programmer #(
    parameter int PULSE_CYC = epv_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Command port
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [epv_pkg::DEV_W-1:0] cmd_dev,
    input wire logic [epv_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [epv_pkg::DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    // Result port
    output logic res_done,
    output logic res_fail,
    output logic [15:0] res_data,
    output logic [epv_pkg::TRY_W-1:0] res_tries,
    // Device pins
    output logic [epv_pkg::ADDR_W-1:0] addr_pin,
    input wire logic [epv_pkg::DATA_W-1:0] data_in,
    output logic [epv_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic [epv_pkg::DEV_COUNT-1:0] select_n,
    output logic gate_n,
    output logic program_strobe_n,
    output logic vpp_high,
    output logic id_mode_trigger_line
);
    localparam logic [epv_pkg::WAIT_W-1:0] W_SETUP = epv_pkg::WAIT_W'(epv_pkg::SETUP_CYC - 1);
    localparam logic [epv_pkg::WAIT_W-1:0] W_HOLD = epv_pkg::WAIT_W'(epv_pkg::HOLD_CYC - 1);
    localparam logic [epv_pkg::WAIT_W-1:0] W_FLOAT = epv_pkg::WAIT_W'(epv_pkg::FLOAT_CYC - 1);
    localparam logic [epv_pkg::WAIT_W-1:0] W_READ =
        epv_pkg::WAIT_W'(epv_pkg::ACC_CYC + epv_pkg::SYNC_STAGES - 1);
    localparam logic [epv_pkg::WAIT_W-1:0] W_PULSE = epv_pkg::WAIT_W'(PULSE_CYC - 1);
    localparam logic [epv_pkg::TRY_W-1:0] TRY_LIMIT = epv_pkg::TRY_W'(epv_pkg::MAX_TRIES);

    epv_pkg::epv_state_t state, next_state;
    logic [epv_pkg::WAIT_W-1:0] wait_cnt, next_wait;
    logic [1:0] op;
    logic [epv_pkg::DEV_W-1:0] dev;
    logic [epv_pkg::DATA_W-1:0] want;
    logic [epv_pkg::TRY_W-1:0] tries, next_tries;
    logic again, next_again;
    logic phase, next_phase;
    logic [epv_pkg::DATA_W-1:0] data_sync;
    logic [15:0] next_res_data;
    logic next_res_fail;

    epv_sync #(.WIDTH(epv_pkg::DATA_W)) u_data_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(data_in),
        .sync_out(data_sync)
    );

    wire tmr_done = (wait_cnt == '0);
    wire accept = (state == epv_pkg::S_IDLE) && cmd_valid;
    wire [1:0] next_op = accept ? cmd_op : op;
    wire [epv_pkg::DEV_W-1:0] next_dev = accept ? cmd_dev : dev;
    wire is_prog = (op == epv_pkg::OP_PROG);
    wire is_sig = (op == epv_pkg::OP_SIG);
    wire matched = (data_sync == want);
    // A cell already at zero where a one is wanted cannot be fixed by more pulses
    wire unfixable = |(want & ~data_sync);
    wire active = (next_state != epv_pkg::S_IDLE) && (next_state != epv_pkg::S_FINISH);

    // Pin levels follow the state being entered, so every pin is a flip-flop
    wire next_strobe_n = !(next_state == epv_pkg::S_PULSE);
    wire next_vpp = active && (next_op == epv_pkg::OP_PROG);
    wire next_drive = (next_op == epv_pkg::OP_PROG) && ((next_state == epv_pkg::S_SETUP)
        || (next_state == epv_pkg::S_PULSE) || (next_state == epv_pkg::S_HOLD));
    wire next_gate = (next_state == epv_pkg::S_VERIFY) || (next_state == epv_pkg::S_CHECK);
    // Only the addressed socket is selected, the rest sit in program inhibit
    wire [epv_pkg::DEV_COUNT-1:0] next_sel_n =
        active ? ~(epv_pkg::DEV_COUNT'(1) << next_dev) : '1;
    wire next_hv = active && (next_op == epv_pkg::OP_SIG);
    wire [epv_pkg::ADDR_W-1:0] next_addr = accept ? ((cmd_op == epv_pkg::OP_SIG) ?
        '0 : cmd_addr) : {addr_pin[epv_pkg::ADDR_W-1:1], next_phase & is_sig | addr_pin[0]};

    always_comb begin
        next_state = state;
        next_wait = tmr_done ? '0 : wait_cnt - 1'b1;
        next_tries = tries;
        next_again = again;
        next_phase = phase;
        next_res_data = res_data;
        next_res_fail = res_fail;
        case (state)
            epv_pkg::S_IDLE: begin
                if (cmd_valid) begin
                    next_state = epv_pkg::S_SETUP;
                    next_wait = W_SETUP;
                    next_tries = '0;
                    next_phase = 1'b0;
                    next_again = 1'b0;
                end
            end
            epv_pkg::S_SETUP: begin
                if (tmr_done && is_prog) begin
                    next_state = epv_pkg::S_PULSE;
                    next_wait = W_PULSE;
                    next_tries = tries + 1'b1;
                end else if (tmr_done) begin
                    next_state = epv_pkg::S_VERIFY;
                    next_wait = W_READ;
                end
            end
            epv_pkg::S_PULSE: begin
                if (tmr_done) begin
                    next_state = epv_pkg::S_HOLD;
                    next_wait = W_HOLD;
                end
            end
            epv_pkg::S_HOLD: begin
                if (tmr_done) begin
                    next_state = epv_pkg::S_TURN;
                    next_wait = W_FLOAT;
                end
            end
            epv_pkg::S_TURN: begin
                // Host lets go of the data pins before the device is gated on
                if (tmr_done) begin
                    next_state = epv_pkg::S_VERIFY;
                    next_wait = W_READ;
                end
            end
            epv_pkg::S_VERIFY: begin
                if (tmr_done) begin
                    next_state = epv_pkg::S_CHECK;
                end
            end
            epv_pkg::S_CHECK: begin
                next_state = epv_pkg::S_RELEASE;
                next_wait = W_FLOAT;
                if (is_prog) begin
                    next_res_data = {8'h00, data_sync};
                    next_again = !matched && !unfixable && (tries < TRY_LIMIT);
                    next_res_fail = !matched;
                end else if (is_sig && !phase) begin
                    // Maker byte first, then raise line zero for the type byte
                    next_res_data = {8'h00, data_sync};
                    next_phase = 1'b1;
                    next_state = epv_pkg::S_VERIFY;
                    next_wait = W_READ;
                end else if (is_sig) begin
                    next_res_data = {data_sync, res_data[7:0]};
                    next_res_fail = 1'b0;
                end else begin
                    // Erased cells come back as all ones here
                    next_res_data = {8'h00, data_sync};
                    next_res_fail = 1'b0;
                end
            end
            epv_pkg::S_RELEASE: begin
                if (tmr_done && again) begin
                    next_state = epv_pkg::S_SETUP;
                    next_wait = W_SETUP;
                    next_again = 1'b0;
                end else if (tmr_done) begin
                    next_state = epv_pkg::S_FINISH;
                end
            end
            epv_pkg::S_FINISH: begin
                next_state = epv_pkg::S_IDLE;
            end
            default: begin
                next_state = epv_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= epv_pkg::S_IDLE;
            wait_cnt <= '0;
            tries <= '0;
            again <= 1'b0;
            phase <= 1'b0;
            op <= epv_pkg::OP_READ;
            dev <= '0;
            want <= '1;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait;
            tries <= next_tries;
            again <= next_again;
            phase <= next_phase;
            op <= next_op;
            dev <= next_dev;
            want <= accept ? cmd_data : want;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addr_pin <= '0;
            data_out <= '1;
            data_oe_n <= 1'b1;
            select_n <= '1;
            gate_n <= 1'b1;
            program_strobe_n <= 1'b1;
            vpp_high <= 1'b0;
            id_mode_trigger_line <= 1'b0;
        end else begin
            addr_pin <= next_addr;
            data_out <= accept ? cmd_data : data_out;
            data_oe_n <= !next_drive;
            select_n <= next_sel_n;
            gate_n <= !next_gate;
            // One shared strobe line serves every paralleled socket
            program_strobe_n <= next_strobe_n;
            vpp_high <= next_vpp;
            id_mode_trigger_line <= next_hv;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmd_ready <= 1'b0;
            res_done <= 1'b0;
            res_fail <= 1'b0;
            res_data <= '0;
            res_tries <= '0;
        end else begin
            cmd_ready <= (next_state == epv_pkg::S_IDLE);
            res_done <= (next_state == epv_pkg::S_FINISH);
            res_fail <= next_res_fail;
            res_data <= next_res_data;
            res_tries <= next_tries;
        end
    end

    // Helper: length of the current strobe-low pulse
    logic [epv_pkg::WAIT_W-1:0] low_len;
    always_ff @(posedge ref_clk) begin
        if (reset || program_strobe_n) begin
            low_len <= '0;
        end else begin
            low_len <= low_len + 1'b1;
        end
    end

    a_prog_entry: assert property (@(posedge ref_clk) disable iff (reset)
        !program_strobe_n |-> vpp_high && (select_n != '1))
        else $error("strobe low without supply or select");
    a_data_driven: assert property (@(posedge ref_clk) disable iff (reset)
        !program_strobe_n |-> !data_oe_n && $stable(data_out))
        else $error("data not held during pulse");
    a_pulse_width: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(program_strobe_n) |-> ($past(low_len) == W_PULSE))
        else $error("program pulse width wrong");
    a_single_target: assert property (@(posedge ref_clk) disable iff (reset)
        !program_strobe_n |-> $onehot(~select_n))
        else $error("more than one socket selected for pulse");
    a_verify_pins: assert property (@(posedge ref_clk) disable iff (reset)
        !gate_n && vpp_high |-> program_strobe_n && data_oe_n && $onehot(~select_n))
        else $error("verify pin levels wrong");
    a_sig_address: assert property (@(posedge ref_clk) disable iff (reset)
        id_mode_trigger_line |-> (addr_pin[epv_pkg::ADDR_W-1:1] == '0) && !vpp_high)
        else $error("signature address lines not low");
    a_sig_sequence: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(id_mode_trigger_line) |-> !addr_pin[0] ##1 !addr_pin[0] [*8])
        else $error("signature did not start with line zero low");
    a_no_contention: assert property (@(posedge ref_clk) disable iff (reset)
        !gate_n |-> data_oe_n && (select_n != '1) ##1 data_oe_n)
        else $error("host drives data while device is gated on");
    a_retry_limit: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(program_strobe_n) |-> ##[1:600] !gate_n && (tries <= TRY_LIMIT))
        else $error("pulse not followed by verify read");
    a_zero_final: assert property (@(posedge ref_clk) disable iff (reset)
        (state == epv_pkg::S_CHECK) && is_prog && unfixable |=> !again)
        else $error("retry on a cell that cannot change");

    c_prog_pass: cover property (@(posedge ref_clk) res_done && is_prog && !res_fail);
    c_prog_retry: cover property (@(posedge ref_clk) res_done && is_prog && (res_tries > 1));
    c_sig_read: cover property (@(posedge ref_clk) res_done && is_sig);
    c_plain_read: cover property (@(posedge ref_clk) res_done && (op == epv_pkg::OP_READ));
endmodule

// [testbench/epv_rom_model.sv]
// Behavioural model of one byte memory socket as seen from the programmer pins
`timescale 1ns/1ps
module epv_rom_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h6c // Arbitrary value
) (
    // Pins
    input wire logic [12:0] addr_pin,
    input wire logic [7:0] bus,
    input wire logic select_n,
    input wire logic gate_n,
    input wire logic program_strobe_n,
    input wire logic vpp_high,
    input wire logic id_mode_trigger_line,
    // Bench controls
    input wire logic [7:0] stuck_one,
    input wire logic slow,
    // Drive towards the shared data bus
    output logic drv_en,
    output logic [7:0] drv_val
);
    logic [7:0] mem [0:8191];
    wire reading = !select_n && !gate_n && program_strobe_n;
    wire sig = id_mode_trigger_line && (addr_pin[12:1] == 12'h000);
    wire [7:0] word = sig ? (addr_pin[0] ? TYPE_CODE : MAKER_CODE) : mem[addr_pin];

    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'hff;
        end
    end

    // Only clears bits; the strobe is shared, so every selected socket takes it
    always @(negedge program_strobe_n) begin
        if (vpp_high && !select_n) begin
            mem[addr_pin] = mem[addr_pin] & (bus | stuck_one);
        end
    end

    assign drv_en = reading;
    // Until access time runs out the pins show the inverse, never a lucky match
    always @(word or reading) begin
        drv_val = ~word;
        drv_val <= #(slow ? 280 : 40) word;
    end
endmodule

// [testbench/test_epv_programmer.sv]
// Self-checking bench for the byte memory programmer
`timescale 1ns/1ps
module test_epv_programmer;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [0:0] cmd_dev = 1'h0;
    logic [12:0] cmd_addr = 13'h0000;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] stuck1 = 8'h00;
    logic slow0 = 1'b0;
    logic [7:0] bus;
    logic [7:0] float_pat = 8'h96;
    wire cmd_ready, res_done, res_fail, data_oe_n, gate_n, program_strobe_n;
    wire vpp_high, id_mode_trigger_line, en0, en1;
    wire [15:0] res_data;
    wire [4:0] res_tries;
    wire [12:0] addr_pin;
    wire [7:0] data_out, val0, val1;
    wire [1:0] select_n;
    int miscompares = 0;
    int cmp_count = 0;

    always #5 ref_clk = ~ref_clk;

    epv_programmer #(.PULSE_CYC(20)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .res_done(res_done), .res_fail(res_fail), .res_data(res_data),
        .res_tries(res_tries), .addr_pin(addr_pin), .data_in(bus), .data_out(data_out),
        .data_oe_n(data_oe_n), .select_n(select_n), .gate_n(gate_n),
        .program_strobe_n(program_strobe_n), .vpp_high(vpp_high),
        .id_mode_trigger_line(id_mode_trigger_line)
    );
    epv_rom_model u_rom0 (
        .addr_pin(addr_pin), .bus(bus), .select_n(select_n[0]), .gate_n(gate_n),
        .program_strobe_n(program_strobe_n), .vpp_high(vpp_high),
        .id_mode_trigger_line(id_mode_trigger_line), .stuck_one(8'h00), .slow(slow0),
        .drv_en(en0), .drv_val(val0)
    );
    epv_rom_model u_rom1 (
        .addr_pin(addr_pin), .bus(bus), .select_n(select_n[1]), .gate_n(gate_n),
        .program_strobe_n(program_strobe_n), .vpp_high(vpp_high),
        .id_mode_trigger_line(id_mode_trigger_line), .stuck_one(stuck1), .slow(1'b0),
        .drv_en(en1), .drv_val(val1)
    );

    // Nobody driving: the wire has no pull, so show a pattern that keeps moving
    always @(posedge ref_clk) float_pat <= ~float_pat;
    always @* begin
        if (!data_oe_n) bus = data_out;
        else if (en0) bus = val0;
        else if (en1) bus = val1;
        else bus = float_pat;
    end

    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    // Two drivers on the data pins at once would be a fight on the bus
    // Looked at mid-cycle so that every pin has settled after its edge
    always @(negedge ref_clk) begin
        if (!reset && ((!data_oe_n && (en0 || en1)) || (en0 && en1))) begin
            $display("MISMATCH bus contention expected %h seen %h", 2'b00, {en0, en1});
            miscompares++;
        end
    end

    task automatic run_cmd(input logic [1:0] op, input logic dev, input logic [12:0] a,
                           input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge ref_clk) #1;
            n++;
        end
        if (n >= 100) begin
            $display("MISMATCH cmd_ready expected %h seen %h", 1'b1, cmd_ready);
            miscompares++;
        end
        cmd_op = op;
        cmd_dev = dev;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(posedge ref_clk) #1;
        cmd_valid = 1'b0;
        n = 0;
        while (res_done !== 1'b1 && n < 20000) begin
            @(posedge ref_clk) #1;
            n++;
        end
        if (n >= 20000) begin
            $display("MISMATCH res_done expected %h seen %h", 1'b1, res_done);
            miscompares++;
        end
    endtask

    task automatic blank_read;
        run_cmd(epv_pkg::OP_READ, 1'b0, 13'h1fff, 8'h00);
        chk("blank byte", 16'h00ff, res_data);
    endtask

    task automatic program_slow_device;
        slow0 = 1'b1;
        run_cmd(epv_pkg::OP_PROG, 1'b0, 13'h1a5, 8'ha5);
        chk("program fail", 16'h0000, {15'h0000, res_fail});
        chk("program tries", 16'h0001, {11'h000, res_tries});
        run_cmd(epv_pkg::OP_READ, 1'b0, 13'h1a5, 8'h00);
        chk("programmed byte", 16'h00a5, res_data);
        slow0 = 1'b0;
    endtask

    task automatic ones_keep_zeros;
        run_cmd(epv_pkg::OP_PROG, 1'b0, 13'h1a5, 8'hff);
        chk("raise zero fail", 16'h0001, {15'h0000, res_fail});
        chk("raise zero tries", 16'h0001, {11'h000, res_tries});
        run_cmd(epv_pkg::OP_READ, 1'b0, 13'h1a5, 8'h00);
        chk("zeros kept", 16'h00a5, res_data);
    endtask

    task automatic other_socket;
        run_cmd(epv_pkg::OP_PROG, 1'b1, 13'h1a5, 8'h3c);
        chk("socket one fail", 16'h0000, {15'h0000, res_fail});
        run_cmd(epv_pkg::OP_READ, 1'b0, 13'h1a5, 8'h00);
        chk("socket zero untouched", 16'h00a5, res_data);
        run_cmd(epv_pkg::OP_READ, 1'b1, 13'h1a5, 8'h00);
        chk("socket one byte", 16'h003c, res_data);
    endtask

    task automatic stuck_retry;
        stuck1 = 8'h01;
        run_cmd(epv_pkg::OP_PROG, 1'b1, 13'h0010, 8'h00);
        chk("stuck fail", 16'h0001, {15'h0000, res_fail});
        chk("stuck tries", 16'(epv_pkg::MAX_TRIES), {11'h000, res_tries});
        stuck1 = 8'h00;
        run_cmd(epv_pkg::OP_READ, 1'b1, 13'h0010, 8'h00);
        chk("stuck byte", 16'h0001, res_data);
    endtask

    task automatic signature;
        run_cmd(epv_pkg::OP_SIG, 1'b1, 13'h1fff, 8'h00);
        chk("signature", 16'h6c5a, res_data);
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        blank_read;
        program_slow_device;
        ones_keep_zeros;
        other_socket;
        stuck_retry;
        signature;
        tally_and_finish;
    end
endmodule
